// ---- design/uadm_defs.svh ----
// constants of the descriptor store: lengths, programmable field positions, timing
// What this block does
// [R01] One configuration holding a control, an audio and a HID interface.
// [R02] Map index at start-up is decoded from the two map-select pins.
// [R03] An EEPROM-loaded map may replace the chosen built-in map.
// [R04] Vendor, product, attributes, power, master controls, output type come from the map.
// [R05] Every descriptor byte is returned whenever the host asks for it once the map is fixed; earlier reads get the error flag.
// [R06] Device descriptor advertises eight bytes for the default control endpoint.
// [R07] Device descriptor states exactly one configuration.
// [R08] Configuration descriptor reports three interfaces and configuration value one.
// [R09] Audio interface offers seven alternate settings, host-selected.
// [R10] Audio-control interface: number zero, audio class, control subclass, no endpoints.
// [R11] Audio-control header: revision 0900, total length 2B00, one streaming interface one.
// [R12] Terminals not controllable; feature unit offers volume, mute, treble, bass, boost.
// [R13] Feature unit: unit 02, source 01, control size 02, channels 0200.
// [R14] Input terminal: ID 01, streaming type, two channels, configuration 0300.
// [R15] Output terminal: ID 03, source 02, programmable type defaulting to 0103.
// [R16] Sink endpoint buffer holds at most 336 bytes per frame.
// [R17] Packet sizes are computed at the top sample rate of 55 kHz.
// [R18] Max packet equals bytes per sample times channels times 56.
// [R19] Map-select pins sampled once after reset; choice held until reset or load.
`ifndef UADM_DEFS_SVH
`define UADM_DEFS_SVH

`define UADM_DEV_LEN 18
`define UADM_ALT_LEN 48
`define UADM_NUM_ALT 6
`define UADM_CFG_LEN 378
`define UADM_CFG_TOTAL 16'h017A
`define UADM_IDX_W 9

`define UADM_MAP_BYTES 10
`define UADM_MAP_VID_LO 0
`define UADM_MAP_VID_HI 1
`define UADM_MAP_PID_LO 2
`define UADM_MAP_PID_HI 3
`define UADM_MAP_ATTR 4
`define UADM_MAP_POWER 5
`define UADM_MAP_MCTL_LO 6
`define UADM_MAP_MCTL_HI 7
`define UADM_MAP_OTT_LO 8
`define UADM_MAP_OTT_HI 9

`define UADM_EP0_MAX_PACKET 8'h08
`define UADM_SAMPLES_PER_FRAME 56
`define UADM_TOP_RATE_KHZ 55
`define UADM_SINK_BUF_BYTES 336
`define UADM_SETTLE_CYCLES 4

`endif

// ---- design/uadm_desc_map.sv ----
// descriptor store of the audio sink: built-in maps, eeprom overlay, byte read port, alt setting
`timescale 1ns/1ps
`include "uadm_defs.svh"
module uadm_desc_map #(
  // all four default maps carry arbitrary identity values
  parameter logic [`UADM_MAP_BYTES*8-1:0] BUILTIN_MAP0 = 80'h0301_0115_00_40_0100_3412,
  parameter logic [`UADM_MAP_BYTES*8-1:0] BUILTIN_MAP1 = 80'h0301_0115_00_40_0200_3412,
  parameter logic [`UADM_MAP_BYTES*8-1:0] BUILTIN_MAP2 = 80'h0301_0115_00_40_0300_3412,
  parameter logic [`UADM_MAP_BYTES*8-1:0] BUILTIN_MAP3 = 80'h0301_0115_00_40_0400_3412
) (
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic I_MAP_SELECT_HIGH_PIN,
  input wire logic I_MAP_SELECT_LOW_PIN,
  input wire logic I_RD_REQ,
  input wire logic I_RD_SEL,
  input wire logic [`UADM_IDX_W-1:0] I_RD_INDEX,
  input wire logic I_LOAD_VALID,
  input wire logic [3:0] I_LOAD_ADDR,
  input wire logic [7:0] I_LOAD_DATA,
  input wire logic I_LOAD_COMMIT,
  input wire logic I_SET_ALT,
  input wire logic [2:0] I_ALT_VALUE,
  output logic O_READY,
  output logic [1:0] O_MAP_INDEX,
  output logic O_MAP_FROM_EEPROM,
  output logic O_RD_VALID,
  output logic [7:0] O_RD_DATA,
  output logic O_RD_LAST,
  output logic O_RD_ERR,
  output logic [2:0] O_ALT_SETTING,
  output logic [8:0] O_MAX_PACKET,
  output logic O_ALT_ERR
);

  localparam int MAP_W = `UADM_MAP_BYTES * 8;
  localparam int SETTLE_W = 3;
  // latch edge must trail three synchroniser stages plus the agreement flop, else the pins read as zero
  localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(`UADM_SETTLE_CYCLES);

  uadm_pkg::uadm_state_t state;
  logic [SETTLE_W-1:0] settle_cnt;
  logic [1:0] pin_level;
  logic [MAP_W-1:0] map_cur;
  logic [MAP_W-1:0] map_stage;
  logic [MAP_W-1:0] next_stage;
  logic [MAP_W-1:0] builtin_sel;

  uadm_pin_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .i_clk(I_REF_CLK),
    .i_rst(I_RST),
    .i_pin({I_MAP_SELECT_HIGH_PIN, I_MAP_SELECT_LOW_PIN}),
    .o_level(pin_level)
  );

  function automatic logic [7:0] map_byte(input logic [MAP_W-1:0] m, input int k);
    map_byte = m[k*8 +: 8];
  endfunction : map_byte

  // bytes per sample rise every two settings, odd settings are mono
  function automatic logic [8:0] max_packet_of(input logic [2:0] alt);
    logic [8:0] sub;
    logic [8:0] ch;
    sub = 9'((int'(alt) + 1) / 2);
    ch = alt[0] ? 9'h001 : 9'h002;
    if (alt == 3'h0 || alt > 3'(`UADM_NUM_ALT))
      max_packet_of = 9'h000;
    else
      max_packet_of = 9'(sub * ch * 9'(`UADM_SAMPLES_PER_FRAME)); // [R17] [R18] [R16]
  endfunction : max_packet_of

  always_comb
  begin
    // code 0 and any unknown pin pair fall through to the first map
    builtin_sel = BUILTIN_MAP0;
    if (pin_level == 2'h1)
      builtin_sel = BUILTIN_MAP1;
    else if (pin_level == 2'h2)
      builtin_sel = BUILTIN_MAP2;
    else if (pin_level == 2'h3)
      builtin_sel = BUILTIN_MAP3;
  end

  // settle wait covers the synchroniser depth before the strap is trusted
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      state <= uadm_pkg::UADM_ST_SETTLE;
      settle_cnt <= '0;
    end
    else
    begin
      case (state)
        uadm_pkg::UADM_ST_SETTLE:
        begin
          settle_cnt <= settle_cnt + 3'h1;
          if (settle_cnt == SETTLE_LAST)
            state <= uadm_pkg::UADM_ST_READY;
        end
        uadm_pkg::UADM_ST_READY:
          state <= uadm_pkg::UADM_ST_READY;
        default:
          state <= uadm_pkg::UADM_ST_SETTLE;
      endcase
    end
  end

  always_comb
  begin
    next_stage = map_stage;
    if (I_LOAD_VALID && I_LOAD_ADDR < 4'(`UADM_MAP_BYTES))
      next_stage[I_LOAD_ADDR*8 +: 8] = I_LOAD_DATA;
  end

  // the pins are looked at only on the settle-to-ready step; later pin changes are ignored
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      map_cur <= '0;
      map_stage <= '0;
      O_MAP_INDEX <= 2'h0;
      O_MAP_FROM_EEPROM <= 1'b0;
      O_READY <= 1'b0;
    end
    else if (state == uadm_pkg::UADM_ST_SETTLE)
    begin
      if (settle_cnt == SETTLE_LAST)
      begin
        map_cur <= builtin_sel; // [R02] [R19]
        map_stage <= builtin_sel;
        O_MAP_INDEX <= pin_level; // [R02]
        O_READY <= 1'b1;
      end
    end
    else
    begin
      // loads land only once ready; before that the stage is still being seeded
      map_stage <= next_stage;
      if (I_LOAD_COMMIT)
      begin
        map_cur <= next_stage; // [R03]
        O_MAP_FROM_EEPROM <= 1'b1;
      end
    end
  end

  logic [7:0] vid_lo;
  logic [7:0] vid_hi;
  logic [7:0] pid_lo;
  logic [7:0] pid_hi;
  logic [7:0] cfg_attr;
  logic [7:0] cfg_power;
  logic [7:0] mctl_lo;
  logic [7:0] mctl_hi;
  logic [7:0] ott_lo;
  logic [7:0] ott_hi;

  assign vid_lo = map_byte(map_cur, `UADM_MAP_VID_LO); // [R04]
  assign vid_hi = map_byte(map_cur, `UADM_MAP_VID_HI);
  assign pid_lo = map_byte(map_cur, `UADM_MAP_PID_LO);
  assign pid_hi = map_byte(map_cur, `UADM_MAP_PID_HI);
  assign cfg_attr = map_byte(map_cur, `UADM_MAP_ATTR);
  assign cfg_power = map_byte(map_cur, `UADM_MAP_POWER);
  assign mctl_lo = map_byte(map_cur, `UADM_MAP_MCTL_LO);
  assign mctl_hi = map_byte(map_cur, `UADM_MAP_MCTL_HI);
  assign ott_lo = map_byte(map_cur, `UADM_MAP_OTT_LO);
  assign ott_hi = map_byte(map_cur, `UADM_MAP_OTT_HI);

  logic [`UADM_DEV_LEN*8-1:0] dev_vec;
  logic [`UADM_NUM_ALT*`UADM_ALT_LEN*8-1:0] alt_vec;
  logic [`UADM_CFG_LEN*8-1:0] cfg_vec;
  logic [15:0] cfg_total;

  assign cfg_total = `UADM_CFG_TOTAL;

  // first byte sits in the top lane; readout flips the index
  assign dev_vec = {
    8'h12, 8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00,
    `UADM_EP0_MAX_PACKET, // [R06]
    vid_lo, vid_hi, pid_lo, pid_hi,
    8'h00, 8'h01, 8'h01, 8'h02, 8'h03,
    8'h01 // [R07]
  };

  genvar a;
  generate
    for (a = 1; a <= `UADM_NUM_ALT; a++)
    begin : g_alt
      localparam logic [7:0] SUB = 8'((a + 1) / 2);
      localparam logic [7:0] CH = (a % 2 == 1) ? 8'h01 : 8'h02;
      localparam logic [7:0] RES = (SUB == 8'h01) ? 8'h08 : ((SUB == 8'h02) ? 8'h10 : 8'h14);
      localparam logic [15:0] MPS = 16'(int'(SUB) * int'(CH) * `UADM_SAMPLES_PER_FRAME); // [R18]
      assign alt_vec[(`UADM_NUM_ALT-a)*`UADM_ALT_LEN*8 +: `UADM_ALT_LEN*8] = {
        8'h0B, 8'h04, 8'h01, 8'(a), 8'h01, 8'h01, 8'h02, 8'h00, 8'h00, 8'h01, 8'h00, // [R09]
        8'h07, 8'h24, 8'h01, 8'h01, 8'h00, 8'h01, 8'h00,
        8'h0E, 8'h24, 8'h02, 8'h01, CH, SUB, RES, 8'h00,
        8'h7E, 8'h13, 8'h00, 8'hE2, 8'hD6, 8'h00, // [R17]
        8'h09, 8'h05, 8'h04, 8'h09, MPS[7:0], MPS[15:8], 8'h01, 8'h00, 8'h00, // [R16]
        8'h07, 8'h25, 8'h01, 8'h00, 8'h02, 8'h00, 8'h02
      };
    end
  endgenerate

  assign cfg_vec = {
    8'h09, 8'h02, cfg_total[7:0], cfg_total[15:8],
    8'h03, 8'h01, 8'h00, cfg_attr, cfg_power, // [R08] [R01]
    8'h0B, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h01, 8'h00, // [R10]
    8'h09, 8'h24, 8'h01, 8'h09, 8'h00, 8'h2B, 8'h00, 8'h01, 8'h01, // [R11]
    8'h0C, 8'h24, 8'h02, 8'h01, 8'h01, 8'h01, 8'h00, 8'h02, 8'h03, 8'h00, 8'h00, 8'h00, // [R14]
    8'h0D, 8'h24, 8'h06, 8'h02, 8'h01, 8'h02, // [R13]
    mctl_lo, mctl_hi, 8'h02, 8'h00, 8'h02, 8'h00, 8'h00, // [R12] [R13]
    8'h09, 8'h24, 8'h03, 8'h03, ott_lo, ott_hi, 8'h00, 8'h02, 8'h00, // [R15] [R12]
    8'h0B, 8'h04, 8'h01, 8'h00, 8'h00, 8'h01, 8'h02, 8'h00, 8'h00, 8'h01, 8'h00, // [R09]
    alt_vec,
    // hid interface with its interrupt-in endpoint three, 64-byte packets every frame
    8'h09, 8'h04, 8'h02, 8'h00, 8'h01, 8'h03, 8'h00, 8'h00, 8'h00, // [R01]
    8'h07, 8'h05, 8'h83, 8'h03, 8'h40, 8'h00, 8'h01
  };

  logic rd_in_range;
  logic rd_is_last;
  logic [7:0] rd_byte;

  always_comb
  begin
    // an index past the selected descriptor is refused rather than wrapped
    rd_in_range = 1'b0;
    rd_is_last = 1'b0;
    rd_byte = 8'h00;
    if (I_RD_SEL == uadm_pkg::UADM_SEL_DEVICE)
    begin
      if (I_RD_INDEX < `UADM_IDX_W'(`UADM_DEV_LEN))
      begin
        rd_in_range = 1'b1;
        rd_is_last = (I_RD_INDEX == `UADM_IDX_W'(`UADM_DEV_LEN - 1));
        rd_byte = dev_vec[(`UADM_DEV_LEN - 1 - int'(I_RD_INDEX))*8 +: 8];
      end
    end
    else if (I_RD_INDEX < `UADM_IDX_W'(`UADM_CFG_LEN))
    begin
      rd_in_range = 1'b1;
      rd_is_last = (I_RD_INDEX == `UADM_IDX_W'(`UADM_CFG_LEN - 1));
      rd_byte = cfg_vec[(`UADM_CFG_LEN - 1 - int'(I_RD_INDEX))*8 +: 8];
    end
  end

  // reads before the map is fixed are refused so the host never sees a half-chosen map
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      O_RD_VALID <= 1'b0;
      O_RD_DATA <= 8'h00;
      O_RD_LAST <= 1'b0;
      O_RD_ERR <= 1'b0;
    end
    else
    begin
      // every request is answered, a refused one with the error flag, so the host never waits on silence
      O_RD_VALID <= I_RD_REQ;
      if (I_RD_REQ && O_READY && rd_in_range)
      begin
        O_RD_DATA <= rd_byte; // [R05]
        O_RD_LAST <= rd_is_last;
        O_RD_ERR <= 1'b0;
      end
      else
      begin
        O_RD_DATA <= 8'h00;
        O_RD_LAST <= 1'b0;
        O_RD_ERR <= I_RD_REQ;
      end
    end
  end

  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      O_ALT_SETTING <= 3'h0;
      O_MAX_PACKET <= 9'h000;
      O_ALT_ERR <= 1'b0;
    end
    else if (I_SET_ALT)
    begin
      if (I_ALT_VALUE <= 3'(`UADM_NUM_ALT))
      begin
        O_ALT_SETTING <= I_ALT_VALUE; // [R09]
        O_MAX_PACKET <= max_packet_of(I_ALT_VALUE); // [R18]
        O_ALT_ERR <= 1'b0;
      end
      else
      begin
        // a refused value leaves the active setting and its packet size alone
        O_ALT_ERR <= 1'b1;
      end
    end
  end

endmodule : uadm_desc_map

// ---- design/uadm_pin_sync.sv ----
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module uadm_pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_pin,
  output logic [WIDTH-1:0] o_level
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end
    else
    begin
      stage1 <= i_pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // a bit moves only once two later stages agree, so a single metastable sample cannot pass
  genvar b;
  generate
    for (b = 0; b < WIDTH; b++)
    begin : g_bit
      always_ff @(posedge i_clk)
      begin
        if (i_rst)
          o_level[b] <= 1'b0;
        else if (stage2[b] == stage3[b])
          o_level[b] <= stage3[b];
      end
    end
  endgenerate

endmodule : uadm_pin_sync

// ---- design/uadm_pkg.sv ----
// types shared by the descriptor store
package uadm_pkg;

  typedef enum logic [1:0] {
    UADM_ST_SETTLE = 2'b00,
    UADM_ST_READY = 2'b01
  } uadm_state_t;

  typedef enum logic {
    UADM_SEL_DEVICE = 1'b0,
    UADM_SEL_CONFIG = 1'b1
  } uadm_desc_sel_t;

endpackage : uadm_pkg

// ---- dv/uadm_desc_map_assertions.sv ----
// port timing checker of the descriptor store
`timescale 1ns/1ps
`include "uadm_defs.svh"
module uadm_chk (
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic I_RD_REQ,
  input wire logic I_RD_SEL,
  input wire logic [`UADM_IDX_W-1:0] I_RD_INDEX,
  input wire logic I_LOAD_COMMIT,
  input wire logic I_SET_ALT,
  input wire logic [2:0] I_ALT_VALUE,
  input wire logic O_READY,
  input wire logic [1:0] O_MAP_INDEX,
  input wire logic O_MAP_FROM_EEPROM,
  input wire logic O_RD_VALID,
  input wire logic [7:0] O_RD_DATA,
  input wire logic O_RD_LAST,
  input wire logic O_RD_ERR,
  input wire logic [2:0] O_ALT_SETTING,
  input wire logic [8:0] O_MAX_PACKET,
  input wire logic O_ALT_ERR
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);
  wire logic dev_rd = I_RD_REQ && O_READY && !I_RD_SEL;
  property p_rd_ans; I_RD_REQ |=> O_RD_VALID; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_rd_idle; !I_RD_REQ |=> !O_RD_VALID && O_RD_DATA == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("answer without request");
  property p_not_ready; I_RD_REQ && !O_READY |=> O_RD_ERR && O_RD_DATA == 8'h00; endproperty
  a_not_ready: assert property (p_not_ready) else $error("read before map chosen");
  property p_ep0; dev_rd && I_RD_INDEX == 9'h007 |=> O_RD_DATA == 8'h08 && !O_RD_ERR; endproperty
  a_ep0: assert property (p_ep0) else $error("control packet size wrong");
  property p_dev_end; dev_rd && I_RD_INDEX == 9'h011 |=> O_RD_LAST && O_RD_DATA == 8'h01; endproperty
  a_dev_end: assert property (p_dev_end) else $error("configuration count wrong");
  property p_dev_over; dev_rd && I_RD_INDEX > 9'h011 |=> O_RD_ERR && !O_RD_LAST; endproperty
  a_dev_over: assert property (p_dev_over) else $error("read past end accepted");
  property p_alt_bad; I_SET_ALT && I_ALT_VALUE == 3'h7 |=> O_ALT_ERR && $stable(O_ALT_SETTING); endproperty
  a_alt_bad: assert property (p_alt_bad) else $error("bad setting taken");
  property p_pkt; I_SET_ALT && I_ALT_VALUE == 3'h6 |=> O_MAX_PACKET == 9'h150; endproperty
  a_pkt: assert property (p_pkt) else $error("packet size wrong");
  property p_hold; O_READY |=> O_READY && $stable(O_MAP_INDEX); endproperty
  a_hold: assert property (p_hold) else $error("map choice moved");
  property p_commit; I_LOAD_COMMIT && O_READY |=> O_MAP_FROM_EEPROM; endproperty
  a_commit: assert property (p_commit) else $error("commit not taken");
endmodule : uadm_chk
bind uadm_desc_map uadm_chk u_chk (.I_REF_CLK, .I_RST, .I_RD_REQ, .I_RD_SEL, .I_RD_INDEX, .I_LOAD_COMMIT,
  .I_SET_ALT, .I_ALT_VALUE, .O_READY, .O_MAP_INDEX, .O_MAP_FROM_EEPROM, .O_RD_VALID, .O_RD_DATA,
  .O_RD_LAST, .O_RD_ERR, .O_ALT_SETTING, .O_MAX_PACKET, .O_ALT_ERR);

// ---- dv/uadm_desc_map_tb_top.sv ----
// testbench of the descriptor store
`timescale 1ns/1ps
module uadm_desc_map_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hi = 1'b0;
  logic lo = 1'b0;
  logic lv = 1'b0;
  logic lc = 1'b0;
  logic sa = 1'b0;
  logic [3:0] la = 4'h0;
  logic [7:0] ld = 8'h00;
  logic [2:0] av = 3'h0;
  logic rq, rs, rdy, fee, vld, lst, err, aerr;
  logic [8:0] ri, mpk;
  logic [1:0] midx;
  logic [7:0] dat;
  logic [2:0] alt;
  int fails = 0;
  int n_tests = 0;
  always #12.5 clk = ~clk;
  uadm_desc_map u_dut (.I_REF_CLK(clk), .I_RST(rst), .I_MAP_SELECT_HIGH_PIN(hi), .I_MAP_SELECT_LOW_PIN(lo),
    .I_RD_REQ(rq), .I_RD_SEL(rs), .I_RD_INDEX(ri), .I_LOAD_VALID(lv), .I_LOAD_ADDR(la), .I_LOAD_DATA(ld),
    .I_LOAD_COMMIT(lc), .I_SET_ALT(sa), .I_ALT_VALUE(av), .O_READY(rdy), .O_MAP_INDEX(midx),
    .O_MAP_FROM_EEPROM(fee), .O_RD_VALID(vld), .O_RD_DATA(dat), .O_RD_LAST(lst), .O_RD_ERR(err),
    .O_ALT_SETTING(alt), .O_MAX_PACKET(mpk), .O_ALT_ERR(aerr));
  uadm_host u_host (.i_clk(clk), .i_valid(vld), .i_data(dat), .i_last(lst), .i_err(err), .o_req(rq),
    .o_sel(rs), .o_index(ri));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic rd(input logic s, input int i, output logic [7:0] d, output logic e, output logic l);
    logic ok;
    u_host.read(s, 9'(i), d, e, l, ok);
    chk("valid", 1, ok);
    if (ok !== 1'b1)
      finish_test();
  endtask : rd
  task automatic go(input int k);
    @(negedge clk);
    rst = 1'b1;
    {hi, lo} = 2'(k);
    repeat (3) @(negedge clk);
    rst = 1'b0;
  endtask : go
  task automatic wait_rdy;
    int n;
    for (n = 0; n < 20 && rdy !== 1'b1; n++) @(negedge clk);
    chk("ready", 1, rdy);
    if (rdy !== 1'b1)
      finish_test();
  endtask : wait_rdy
  task automatic t_map;
    logic [7:0] d;
    logic e, l;
    for (int k = 3; k >= 0; k--)
    begin
      go(k);
      rd(0, 7, d, e, l);
      chk("early err", 1, e);
      lv = 1'b1;
      lc = 1'b1;
      @(negedge clk);
      lv = 1'b0;
      lc = 1'b0;
      wait_rdy();
      chk("map index", k, midx);
      chk("from eeprom", 0, fee);
      rd(0, 11, d, e, l);
      chk("product hi", k + 1, d);
      {hi, lo} = ~2'(k);
      repeat (6) @(negedge clk);
      chk("map held", k, midx);
      rd(0, 11, d, e, l);
      chk("product held", k + 1, d);
    end
    $display("map select done");
  endtask : t_map
  task automatic t_dev;
    logic [7:0] x [18] = '{8'h12, 8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h08, 8'h12, 8'h34,
      8'h00, 8'h01, 8'h00, 8'h01, 8'h01, 8'h02, 8'h03, 8'h01};
    logic [7:0] d;
    logic e, l;
    for (int i = 0; i < 18; i++)
    begin
      rd(0, i, d, e, l);
      chk("dev byte", x[i], d);
      chk("dev last", i == 17, l);
    end
    rd(0, 18, d, e, l);
    chk("dev over", 1, e);
    $display("device descriptor done");
  endtask : t_dev
  task automatic t_cfg;
    logic [16:0] x [26] = '{{9'd0, 8'h09}, {9'd2, 8'h7A}, {9'd3, 8'h01}, {9'd4, 8'h03}, {9'd5, 8'h01},
      {9'd7, 8'h40}, {9'd11, 8'h00}, {9'd13, 8'h00}, {9'd14, 8'h01}, {9'd15, 8'h01}, {9'd23, 8'h09},
      {9'd25, 8'h2B}, {9'd27, 8'h01}, {9'd28, 8'h01}, {9'd32, 8'h01}, {9'd36, 8'h02}, {9'd37, 8'h03},
      {9'd44, 8'h02}, {9'd45, 8'h01}, {9'd46, 8'h02}, {9'd47, 8'h15}, {9'd49, 8'h02}, {9'd51, 8'h02},
      {9'd57, 8'h03}, {9'd58, 8'h01}, {9'd61, 8'h02}};
    logic [7:0] d;
    logic e, l;
    foreach (x[i])
    begin
      rd(1, x[i][16:8], d, e, l);
      chk("cfg byte", x[i][7:0], d);
    end
    rd(1, 377, d, e, l);
    chk("cfg last", 1, l);
    rd(1, 378, d, e, l);
    chk("cfg over", 1, e);
    $display("configuration done");
  endtask : t_cfg
  task automatic set_alt(input logic [2:0] v);
    @(negedge clk);
    sa = 1'b1;
    av = v;
    @(negedge clk);
    sa = 1'b0;
  endtask : set_alt
  task automatic t_alt;
    logic [8:0] x [7] = '{9'd0, 9'd56, 9'd112, 9'd112, 9'd224, 9'd168, 9'd336};
    logic [7:0] d, h;
    logic e, l;
    for (int n = 0; n < 7; n++)
    begin
      set_alt(3'(n));
      chk("alt", n, alt);
      chk("max packet", x[n], mpk);
      if (n > 0)
      begin
        rd(1, 110 + 48 * (n - 1), d, e, l);
        rd(1, 111 + 48 * (n - 1), h, e, l);
        chk("ep packet", x[n], {h, d});
      end
    end
    set_alt(3'h7);
    chk("alt err", 1, aerr);
    chk("alt kept", 6, alt);
    set_alt(3'h3);
    chk("alt err clr", 0, aerr);
    $display("alternate settings done");
  endtask : t_alt
  task automatic t_load;
    logic [7:0] d;
    logic e, l;
    @(negedge clk);
    lv = 1'b1;
    la = 4'h0;
    ld = 8'hAA;
    @(negedge clk);
    la = 4'hA;
    ld = 8'h55;
    @(negedge clk);
    la = 4'h8;
    ld = 8'h66;
    lc = 1'b1;
    @(negedge clk);
    lv = 1'b0;
    lc = 1'b0;
    chk("from eeprom", 1, fee);
    rd(0, 8, d, e, l);
    chk("vendor lo", 8'hAA, d);
    rd(0, 10, d, e, l);
    chk("product lo", 8'h00, d);
    rd(1, 58, d, e, l);
    chk("out type lo", 8'h66, d);
    rd(1, 59, d, e, l);
    chk("out type hi", 8'h03, d);
    $display("eeprom load done");
  endtask : t_load
  initial
  begin
    t_map();
    t_dev();
    t_cfg();
    t_alt();
    t_load();
    finish_test();
  end
endmodule : uadm_desc_map_tb_top

// ---- dv/uadm_host.sv ----
// host model issuing descriptor byte reads
`timescale 1ns/1ps
module uadm_host (
  input wire logic i_clk,
  input wire logic i_valid,
  input wire logic [7:0] i_data,
  input wire logic i_last,
  input wire logic i_err,
  output logic o_req,
  output logic o_sel,
  output logic [8:0] o_index
);
  initial
  begin
    o_req = 1'b0;
    o_sel = 1'b0;
    o_index = 9'h000;
  end
  // index is inverted once released so a stale value cannot pass
  task automatic read(input logic s, input logic [8:0] i, output logic [7:0] d, output logic e,
    output logic l, output logic ok);
    @(negedge i_clk);
    o_req = 1'b1;
    o_sel = s;
    o_index = i;
    // the answer is registered on the taking edge and stands only until the next one
    @(negedge i_clk);
    ok = i_valid;
    d = i_data;
    e = i_err;
    l = i_last;
    o_req = 1'b0;
    o_index = ~i;
  endtask : read
endmodule : uadm_host
